/* common/ubd_pkg.sv */
// Purpose: Shared constants and carriers for the receive-error status and baud divider block
// Assumes: Byte-wide register port, two serial channels, one core clock
// Notes:   Rules are listed below; the logic carries them out without tagging them
// Function
// - A received character with an error shows which kind of error it was in separate flag bits.
// - The status register is 8 bits, read only, cleared by reset, with bits 7 to 3 always zero.
// - Bit 2 is set when the received parity does not match the configured parity, else zero.
// - Bit 1 is set when no valid stop bit ends the received character.
// - Each channel has an 8-bit read-write divisor register, byte written, cleared by reset.
// - The serial clock is the baud source clock divided by the divisor k, for k from 8 to 255.
// - The baud source is the external clock pin, core clock over powers of two to 512, or a timer.
// - The reception controller checks errors on every receive and updates the flags to match.
package ubd_pkg;

  localparam int          CH_NUM = 2;
  localparam logic [31:0] STS_ADDR [CH_NUM] = '{32'hfffff302, 32'hfffff312};
  localparam logic [31:0] DIV_ADDR [CH_NUM] = '{32'hfffff304, 32'hfffff314};

  localparam int          PE_BIT  = 2;
  localparam int          FE_BIT  = 1;
  localparam int          OV_BIT  = 0;
  localparam int          FLAG_W  = 3;

  localparam logic [7:0]  STS_RST = 8'h00;
  localparam logic [7:0]  DIV_RST = 8'h00;
  localparam logic [7:0]  DIV_MIN = 8'h08;

  localparam int          PRE_W     = 9;
  localparam logic [3:0]  SEL_EXT   = 4'h0;
  localparam logic [3:0]  SEL_TIMER = 4'h7;
  localparam logic [3:0]  SEL_LAST  = 4'hb;

  // One receive-side event group from the reception controller, same clock
  typedef struct packed {
    logic done;
    logic parityBad;
    logic stopMissing;
    logic bufRead;
  } ubd_rx_evt_s;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [31:0] addr;
    logic [7:0]  wdata;
  } ubd_bus_req_s;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } ubd_bus_rsp_s;

endpackage : ubd_pkg

/* hw/ubd_baud_divider.sv */
// Purpose: Divide the selected baud source ticks by the programmed divisor
// Assumes: srcTick is a one-cycle pulse on core_clk
// Notes:   Divisors below the minimum keep the counter at zero, so a stopped port is harmless
`timescale 1ns/1ps
module ubd_baud_divider #(
  parameter int DIV_W = 8
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Source and setting
  input  wire logic             srcTick,
  input  wire logic [DIV_W-1:0] divisor,
  // Serial clock tick
  output logic                  baudTick
);
  import ubd_pkg::*;

  logic [DIV_W-1:0] cnt_ff;
  logic             baudTick_ff;
  logic             divOk;

  if (DIV_W != 8) begin : g_bad_width
    $error("ubd_baud_divider supports DIV_W of 8 only");
  end

  assign divOk    = divisor >= DIV_MIN;
  assign baudTick = baudTick_ff;

  // Wrap on >= so a smaller divisor written mid-count cannot strand the counter
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cnt_ff      <= '0;
      baudTick_ff <= 1'b0;
    end else if (!divOk) begin
      cnt_ff      <= '0;
      baudTick_ff <= 1'b0;
    end else if (srcTick && (cnt_ff >= divisor - 8'h01)) begin
      cnt_ff      <= '0;
      baudTick_ff <= 1'b1;
    end else begin
      cnt_ff      <= srcTick ? cnt_ff + 8'h01 : cnt_ff;
      baudTick_ff <= 1'b0;
    end
  end

  a_div_stopped: assert property (@(posedge core_clk) disable iff (!rst_n)
    (divisor < DIV_MIN) |=> !baudTick)
    else $error("serial tick while divisor below minimum");

  a_tick_gap: assert property (@(posedge core_clk) disable iff (!rst_n)
    baudTick |=> !baudTick [*7])
    else $error("serial ticks closer than the minimum divisor");

  a_tick_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
    baudTick |-> $past(srcTick) && $past(divisor) >= DIV_MIN)
    else $error("serial tick without a source tick");

endmodule : ubd_baud_divider

/* hw/ubd_uart_status_baud.sv */
// Purpose: Receive-error status and baud divider registers for two serial channels
// Assumes: Reception controller and timer outputs run on core_clk; external clock pins do not
// Notes:   Register port is a one-cycle byte strobe; read data follows one cycle later
`timescale 1ns/1ps
module ubd_uart_status_baud (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  // Register port
  input  ubd_pkg::ubd_bus_req_s     busReq,
  output ubd_pkg::ubd_bus_rsp_s     busRsp,
  // Reception controller events
  input  ubd_pkg::ubd_rx_evt_s      rxEvt [ubd_pkg::CH_NUM],
  // Baud source selection and sources
  input  wire logic [2:0]           prescalerSelectLow [ubd_pkg::CH_NUM],
  input  wire logic [ubd_pkg::CH_NUM-1:0] prescalerSelectHigh,
  input  wire logic [ubd_pkg::CH_NUM-1:0] extClkPin,
  input  wire logic [ubd_pkg::CH_NUM-1:0] timerOut,
  // Results
  output logic [ubd_pkg::CH_NUM-1:0] baudTick,
  output logic [ubd_pkg::FLAG_W-1:0] rxErrorFlags [ubd_pkg::CH_NUM]
);
  import ubd_pkg::*;

  // Pick the source tick for one channel from its prescaler select code
  function automatic logic srcTickOf(input logic [3:0]       sel,
                                     input logic [PRE_W-1:0] pre,
                                     input logic             extEdge,
                                     input logic             tmrEdge);
    logic [PRE_W-1:0] mask;
    int               m;
    mask = '0;
    m    = 0;
    if (sel == SEL_EXT) begin
      return extEdge;
    end
    if (sel == SEL_TIMER) begin
      return tmrEdge;
    end
    if (sel > SEL_LAST) begin
      return 1'b0;
    end
    m    = (sel < SEL_TIMER) ? int'(sel) - 1 : int'(sel) - 2;
    mask = PRE_W'((1 << m) - 1);
    return &(pre | ~mask);
  endfunction : srcTickOf

  logic [PRE_W-1:0]  preCnt_ff;
  logic [7:0]        divisor_ff   [CH_NUM];
  logic [FLAG_W-1:0] flags_ff     [CH_NUM];
  logic [CH_NUM-1:0] bufFull_ff;
  logic [CH_NUM-1:0] extSync1_ff;
  logic [CH_NUM-1:0] extSync2_ff;
  logic [CH_NUM-1:0] extPrev_ff;
  logic [CH_NUM-1:0] tmrPrev_ff;
  logic [CH_NUM-1:0] srcTick;
  logic [CH_NUM-1:0] overrun;
  logic [3:0]        selCode      [CH_NUM];
  ubd_bus_rsp_s      busRsp_ff;
  logic [7:0]        nxt_rdata;

  assign busRsp = busRsp_ff;

  // Free-running power-of-two prescaler shared by both channels
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      preCnt_ff <= '0;
    end else begin
      preCnt_ff <= preCnt_ff + 9'h001;
    end
  end

  // External clock pins are asynchronous; edges are taken after the second stage
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      extSync1_ff <= '0;
      extSync2_ff <= '0;
      extPrev_ff  <= '0;
      tmrPrev_ff  <= '0;
    end else begin
      extSync1_ff <= extClkPin;
      extSync2_ff <= extSync1_ff;
      extPrev_ff  <= extSync2_ff;
      tmrPrev_ff  <= timerOut;
    end
  end

  // Read decode; unmapped addresses read as zero
  always_comb begin
    nxt_rdata = 8'h00;
    for (int i = 0; i < CH_NUM; i++) begin
      if (busReq.addr == STS_ADDR[i]) begin
        nxt_rdata = {5'h00, flags_ff[i]};
      end
      if (busReq.addr == DIV_ADDR[i]) begin
        nxt_rdata = divisor_ff[i];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      busRsp_ff <= '0;
    end else begin
      busRsp_ff.valid <= busReq.rd;
      busRsp_ff.data  <= busReq.rd ? nxt_rdata : 8'h00;
    end
  end

  for (genvar i = 0; i < CH_NUM; i++) begin : g_ch
    assign selCode[i]      = {prescalerSelectHigh[i], prescalerSelectLow[i]};
    assign srcTick[i]      = srcTickOf(selCode[i], preCnt_ff,
                                       extSync2_ff[i] & ~extPrev_ff[i],
                                       timerOut[i] & ~tmrPrev_ff[i]);
    // A read in the same cycle as a completion served the older character
    assign overrun[i]      = rxEvt[i].done & bufFull_ff[i] & ~rxEvt[i].bufRead;
    assign rxErrorFlags[i] = flags_ff[i];

    // Divisor register, byte write only; status addresses ignore writes
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        divisor_ff[i] <= DIV_RST;
      end else if (busReq.wr && busReq.addr == DIV_ADDR[i]) begin
        divisor_ff[i] <= busReq.wdata;
      end
    end

    // Completion sets the holding buffer busy and wins over a read in the same cycle
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        bufFull_ff[i] <= 1'b0;
      end else if (rxEvt[i].done) begin
        bufFull_ff[i] <= 1'b1;
      end else if (rxEvt[i].bufRead) begin
        bufFull_ff[i] <= 1'b0;
      end
    end

    // Flags describe only the latest completed character
    always_ff @(posedge core_clk) begin
      if (!rst_n) begin
        flags_ff[i] <= STS_RST[FLAG_W-1:0];
      end else if (rxEvt[i].done) begin
        flags_ff[i][PE_BIT] <= rxEvt[i].parityBad;
        flags_ff[i][FE_BIT] <= rxEvt[i].stopMissing;
        flags_ff[i][OV_BIT] <= overrun[i];
      end
    end

    ubd_baud_divider #(
      .DIV_W    (8)
    ) u_div (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .srcTick  (srcTick[i]),
      .divisor  (divisor_ff[i]),
      .baudTick (baudTick[i])
    );

    a_flags_refresh: assert property (@(posedge core_clk) disable iff (!rst_n)
      rxEvt[i].done |=> flags_ff[i] == {$past(rxEvt[i].parityBad),
                                        $past(rxEvt[i].stopMissing), $past(overrun[i])})
      else $error("error flags not refreshed on completion");

    a_flags_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
      !rxEvt[i].done |=> $stable(flags_ff[i]))
      else $error("error flags changed without a completion");

    a_overrun_pair: assert property (@(posedge core_clk) disable iff (!rst_n)
      (rxEvt[i].done && !rxEvt[i].bufRead) ##1 rxEvt[i].done [*1] ##0 !rxEvt[i].bufRead
      |=> flags_ff[i][OV_BIT])
      else $error("second unread completion did not flag overrun");

    a_overrun_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
      (rxEvt[i].done && !bufFull_ff[i]) |=> !flags_ff[i][OV_BIT])
      else $error("overrun flagged with empty buffer");

    a_src_fxx: assert property (@(posedge core_clk) disable iff (!rst_n)
      (selCode[i] == 4'h1) |-> srcTick[i])
      else $error("undivided source selection did not tick every cycle");

    a_src_max: assert property (@(posedge core_clk) disable iff (!rst_n)
      (selCode[i] == SEL_LAST) |-> (srcTick[i] == (preCnt_ff == 9'h1ff)))
      else $error("divide by 512 source ticks at the wrong count");

    a_div_write: assert property (@(posedge core_clk) disable iff (!rst_n)
      (busReq.wr && busReq.addr == DIV_ADDR[i]) |=> divisor_ff[i] == $past(busReq.wdata))
      else $error("divisor write not stored");
  end

  a_upper_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    (busReq.rd && (busReq.addr == STS_ADDR[0] || busReq.addr == STS_ADDR[1]))
    |=> busRsp_ff.valid && busRsp_ff.data[7:3] == 5'h00)
    else $error("status read shows nonzero upper bits");

  a_reset_clear: assert property (@(posedge core_clk)
    !rst_n |=> flags_ff[0] == '0 && flags_ff[1] == '0 && divisor_ff[0] == DIV_RST)
    else $error("registers not cleared by reset");

endmodule : ubd_uart_status_baud

/* test/test_ubd_uart_status_baud.sv */
// Purpose: Register, error flag and baud tick checks for both channels
// Assumes: Inputs change on falling edges; outputs sampled there
// Notes:   Divisor is rewritten only between measurements, never mid-transfer
`timescale 1ns/1ps
module test_ubd_uart_status_baud;
  import ubd_pkg::*;

  localparam logic [6:0]  EVT_TAB [5] = '{7'h44, 7'h32, 7'h01, 7'h08, 7'h67};
  localparam logic [0:0]  BCH [7]  = '{1'h0, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0};
  localparam logic [3:0]  BSEL [7] = '{4'h1, 4'h2, 4'h7, 4'h0, 4'hb, 4'h1, 4'h1};
  localparam logic [7:0]  BDIV [7] = '{8'h08, 8'h09, 8'h08, 8'h08, 8'h08, 8'hff, 8'h07};
  localparam logic [15:0] BPER [7] = '{16'h0008, 16'h0012, 16'h0020, 16'h0030,
                                       16'h1000, 16'h00ff, 16'h0000};

  logic              coreClk;
  logic              rstN;
  ubd_bus_req_s      busReq;
  ubd_bus_rsp_s      busRsp;
  ubd_rx_evt_s       rxEvt [CH_NUM];
  logic [2:0]        prescalerSelectLow [CH_NUM];
  logic [CH_NUM-1:0] prescalerSelectHigh;
  logic [CH_NUM-1:0] extClkPin;
  logic [CH_NUM-1:0] timerOut;
  logic [CH_NUM-1:0] baudTick;
  logic [FLAG_W-1:0] rxErrorFlags [CH_NUM];
  int                failCount;
  int                nCompared;
  int                n;

  ubd_uart_status_baud ubd_uart_status_baud_i (
    .core_clk(coreClk), .rst_n(rstN), .busReq(busReq), .busRsp(busRsp), .rxEvt(rxEvt),
    .prescalerSelectLow(prescalerSelectLow), .prescalerSelectHigh(prescalerSelectHigh),
    .extClkPin(extClkPin), .timerOut(timerOut), .baudTick(baudTick),
    .rxErrorFlags(rxErrorFlags));

  ubd_rx_partner ubd_rx_partner_i (.core_clk(coreClk), .rxEvt(rxEvt));

  initial begin
    coreClk = 1'b0;
    forever #4 coreClk = ~coreClk;
  end

  // Free-running timer and external clock sources at different rates
  initial begin
    timerOut = '0;
    forever begin
      repeat (2) @(negedge coreClk);
      timerOut = ~timerOut;
    end
  end
  initial begin
    extClkPin = '0;
    forever begin
      repeat (3) @(negedge coreClk);
      extClkPin = ~extClkPin;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    nCompared++;
    if (seen !== exp) begin
      failCount++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic busWrite(input logic [31:0] a, input logic [7:0] d);
    busReq = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(negedge coreClk);
    busReq = '0;
  endtask : busWrite

  task automatic rdChk(input logic [31:0] a, input logic [7:0] exp);
    busReq = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
    @(negedge coreClk);
    busReq = '0;
    check({15'h0000, busRsp.valid}, 16'h0001);
    check({8'h00, busRsp.data}, {8'h00, exp});
  endtask : rdChk

  task automatic summarize();
    $display("compared %0d mismatches %0d", nCompared, failCount);
    if (failCount == 0 && nCompared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  // Longest case is about 27000 cycles; allow generous margin
  initial begin
    #(8 * 60000);
    failCount++;
    summarize();
  end

  initial begin
    failCount = 0;
    nCompared = 0;
    rstN = 1'b0;
    busReq = '0;
    prescalerSelectLow = '{default: 3'h0};
    prescalerSelectHigh = '0;
    repeat (20) @(negedge coreClk);
    rstN = 1'b1;
    for (int ch = 0; ch < CH_NUM; ch++) begin
      rdChk(STS_ADDR[ch], STS_RST);
      rdChk(DIV_ADDR[ch], DIV_RST);
    end
    rdChk(32'hfffff300, 8'h00);
    $display("test reset values done");
    // Each entry: parity, stop, same-cycle read, drain first, expected flags
    for (int ch = 0; ch < CH_NUM; ch++) begin
      for (int e = 0; e < 5; e++) begin
        if (EVT_TAB[e][3]) ubd_rx_partner_i.drain(ch);
        ubd_rx_partner_i.finish(ch, EVT_TAB[e][6], EVT_TAB[e][5], EVT_TAB[e][4]);
        check({13'h0000, rxErrorFlags[ch]}, {13'h0000, EVT_TAB[e][2:0]});
        rdChk(STS_ADDR[ch], {5'h00, EVT_TAB[e][2:0]});
      end
    end
    $display("test error flags done");
    for (int ch = 0; ch < CH_NUM; ch++) begin
      busWrite(STS_ADDR[ch], 8'hff);
      rdChk(STS_ADDR[ch], 8'h07);
      busWrite(DIV_ADDR[ch], 8'h5a);
      rdChk(DIV_ADDR[ch], 8'h5a);
    end
    $display("test register access done");
    for (int b = 0; b < 7; b++) begin
      prescalerSelectLow[BCH[b]] = BSEL[b][2:0];
      prescalerSelectHigh[BCH[b]] = BSEL[b][3];
      busWrite(DIV_ADDR[BCH[b]], BDIV[b]);
      repeat (3) @(negedge coreClk);
      for (int w = 0; w < 9000 && baudTick[BCH[b]] !== 1'b1; w++) @(negedge coreClk);
      n = 0;
      repeat (2) begin
        @(negedge coreClk);
        n = 1;
        while (baudTick[BCH[b]] !== 1'b1 && n < 9000) begin
          @(negedge coreClk);
          n++;
        end
      end
      if (BPER[b] == 16'h0000) check({15'h0000, n == 9000}, 16'h0001);
      else check(n[15:0], BPER[b]);
    end
    $display("test baud divider done");
    summarize();
  end
endmodule : test_ubd_uart_status_baud

/* test/ubd_rx_partner.sv */
// Purpose: Reception controller stand-in that reports character completions
// Assumes: Tasks are entered just after a falling edge of core_clk
// Notes:   Error qualifiers are raised only when a scenario asks for them
`timescale 1ns/1ps
module ubd_rx_partner (
  // Clock
  input  wire logic            core_clk,
  // Events toward the block
  output ubd_pkg::ubd_rx_evt_s rxEvt [ubd_pkg::CH_NUM]
);
  import ubd_pkg::*;

  initial begin
    rxEvt = '{default: '0};
  end

  // One-cycle completion with its error qualifiers
  task automatic finish(input int ch, input logic par, input logic stp, input logic rdSame);
    rxEvt[ch] = '{done: 1'b1, parityBad: par, stopMissing: stp, bufRead: rdSame};
    @(negedge core_clk);
    rxEvt[ch] = '0;
  endtask : finish

  // Software emptying the receive holding buffer
  task automatic drain(input int ch);
    rxEvt[ch].bufRead = 1'b1;
    @(negedge core_clk);
    rxEvt[ch] = '0;
  endtask : drain
endmodule : ubd_rx_partner
